// >>> core/analog_limit_events.sv
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// How it works
// - pin-function bit 0 resets to 1, writable; 0 gives pin to analog channel 0.
// - pin-function bit 1 resets to 1, writable; 0 gives pin to analog channel 1.
// - pin-function bit 2 resets to 1 and stays writable.
// - bits 3 and 4 power up 0 when remote diode 1 present, else 1.
// - bits 5 and 6 power up 0 when remote diode 2 present, else 1.
// - pin-function bit 7 is read-only zero.
// - behaviour bit 0 asserts cascaded fault on high-limit exceed.
// - behaviour bit 1 sends fans to alarm speed on high-limit exceed.
// - behaviour bit 2 asserts the interrupt on high-limit exceed.
// - behaviour bit 3 picks low-limit direction: 1 above, 0 below.
// - behaviour bit 4 asserts cascaded fault on low-limit event.
// - behaviour bit 5 sends fans to alarm speed on low-limit event.
// - behaviour bit 6 asserts the interrupt on low-limit event.
// - behaviour bit 7 latches any out-of-limit event until written 0.
// - fan 1 gets a channel's alarm speed only when that channel's mask bit 0 set.
// - fan 2 gets a channel's alarm speed only when that channel's mask bit 1 set.
// - high limit per channel, writable, resets to all ones.
// - low limit per channel, writable, resets to zero.
module analog_limit_events (
  input  wire logic                       sys_clk,
  input  wire logic                       rst_n,
  input  wire logic [ain_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  output logic      [1:0]                 response,
  input  wire logic [7:0]                 analog_in_ch0,
  input  wire logic                       analog_in_ch0_valid,
  input  wire logic [7:0]                 analog_in_ch1,
  input  wire logic                       analog_in_ch1_valid,
  input  wire logic                       remote_diode_1,
  input  wire logic                       remote_diode_2,
  input  wire logic                       other_fault,
  input  wire logic                       other_int,
  input  wire logic                       other_fan1_alarm,
  input  wire logic                       other_fan2_alarm,
  output logic      [7:0]                 pin_function,
  output logic                            cascaded_fault_out_n,
  output logic                            int_n,
  output logic                            fan1_alarm,
  output logic                            fan2_alarm
);
  typedef struct packed {
    logic            wait_q;
    logic [7:0]      rdata;
    logic [1:0]      resp;
    logic [7:0]      pin_func;
    logic [1:0]      init_cnt;
    logic            init_done;
    logic            d1_s1;
    logic            d1_s2;
    logic            d2_s1;
    logic            d2_s2;
    logic [1:0][7:0] behav;
    logic [1:0][7:0] mask;
    logic [1:0][7:0] hi;
    logic [1:0][7:0] lo;
    logic [1:0][7:0] meas;
    logic            fault_n;
    logic            int_n;
    logic            fan1;
    logic            fan2;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;

  logic [1:0][7:0] meas_in;
  logic [1:0]      meas_vld;
  logic [1:0]      hi_cond;
  logic [1:0]      lo_cond;
  logic [1:0]      any_evt;
  logic [1:0]      fault_req;
  logic [1:0]      int_req;
  logic [1:0]      alarm_req;
  logic            req;
  logic            go;
  logic            wr_go;
  logic            hit;
  logic [7:0]      idx;
  logic [7:0]      rd_val;

  assign meas_in  = {analog_in_ch1, analog_in_ch0};
  assign meas_vld = {analog_in_ch1_valid, analog_in_ch0_valid};

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_ch
      // a channel only reports while its pin is handed to the converter
      limit_channel u_chan (
        .sys_clk         (sys_clk),
        .rst_n           (rst_n),
        .enable          (!s_q.pin_func[c]),
        .lo_above        (s_q.behav[c][ain_pkg::BH_LO_ABOVE]),
        .upper_threshold (s_q.hi[c]),
        .lower_threshold (s_q.lo[c]),
        .meas            (meas_in[c]),
        .meas_valid      (meas_vld[c]),
        .hi_cond         (hi_cond[c]),
        .lo_cond         (lo_cond[c])
      );
      assign any_evt[c]   = hi_cond[c] || lo_cond[c];
      assign fault_req[c] = (hi_cond[c] && s_q.behav[c][ain_pkg::BH_HI_FAULT])
                         || (lo_cond[c] && s_q.behav[c][ain_pkg::BH_LO_FAULT]);
      assign alarm_req[c] = (hi_cond[c] && s_q.behav[c][ain_pkg::BH_HI_ALARM])
                         || (lo_cond[c] && s_q.behav[c][ain_pkg::BH_LO_ALARM]);
      assign int_req[c]   = (hi_cond[c] && s_q.behav[c][ain_pkg::BH_HI_INT])
                         || (lo_cond[c] && s_q.behav[c][ain_pkg::BH_LO_INT]);
    end
  endgenerate

  // request taken one cycle after it is first seen
  assign req   = read || write;
  assign go    = req && !s_q.wait_q;
  assign wr_go = go && write && byteenable[0];
  assign idx   = address[ain_pkg::ADDR_W-1:2];

  always_comb begin
    hit    = (address[1:0] == 2'h0);
    rd_val = 8'h00;
    case (idx)
      ain_pkg::IDX_PIN_FUNC: rd_val = s_q.pin_func & ain_pkg::PIN_FUNC_WM;
      ain_pkg::IDX_BEHAV0:   rd_val = s_q.behav[0];
      ain_pkg::IDX_BEHAV1:   rd_val = s_q.behav[1];
      ain_pkg::IDX_MASK0:    rd_val = s_q.mask[0];
      ain_pkg::IDX_MASK1:    rd_val = s_q.mask[1];
      ain_pkg::IDX_HI0:      rd_val = s_q.hi[0];
      ain_pkg::IDX_HI1:      rd_val = s_q.hi[1];
      ain_pkg::IDX_LO0:      rd_val = s_q.lo[0];
      ain_pkg::IDX_LO1:      rd_val = s_q.lo[1];
      ain_pkg::IDX_MEAS0:    rd_val = s_q.meas[0];
      ain_pkg::IDX_MEAS1:    rd_val = s_q.meas[1];
      default:               hit = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;

    // bus handshake
    if (req && s_q.wait_q) begin
      s_d.wait_q = 1'b0;
      s_d.rdata  = (read && hit) ? rd_val : 8'h00;
      s_d.resp   = hit ? ain_pkg::RESP_OK : ain_pkg::RESP_ERR;
    end else begin
      s_d.wait_q = 1'b1;
    end

    // straps pass two flops before use
    s_d.d1_s1 = remote_diode_1;
    s_d.d1_s2 = s_q.d1_s1;
    s_d.d2_s1 = remote_diode_2;
    s_d.d2_s2 = s_q.d2_s1;

    // diode straps are taken once the synchroniser has settled after reset
    if (!s_q.init_done) begin
      if (s_q.init_cnt == ain_pkg::SETTLE_CYCLES - 2'h1) begin
        s_d.init_done = 1'b1;
        s_d.pin_func[ain_pkg::PF_D1_LO] = !s_q.d1_s2;
        s_d.pin_func[ain_pkg::PF_D1_HI] = !s_q.d1_s2;
        s_d.pin_func[ain_pkg::PF_D2_LO] = !s_q.d2_s2;
        s_d.pin_func[ain_pkg::PF_D2_HI] = !s_q.d2_s2;
      end else begin
        s_d.init_cnt = s_q.init_cnt + 2'h1;
      end
    end

    // software writes; a write in the strap cycle wins over the strap
    if (wr_go && hit) begin
      case (idx)
        ain_pkg::IDX_PIN_FUNC: s_d.pin_func = writedata[7:0] & ain_pkg::PIN_FUNC_WM;
        ain_pkg::IDX_BEHAV0: begin
          s_d.behav[0][6:0] = writedata[6:0];
          s_d.behav[0][7]   = s_q.behav[0][7] && writedata[7];
        end
        ain_pkg::IDX_BEHAV1: begin
          s_d.behav[1][6:0] = writedata[6:0];
          s_d.behav[1][7]   = s_q.behav[1][7] && writedata[7];
        end
        ain_pkg::IDX_MASK0: s_d.mask[0] = writedata[7:0];
        ain_pkg::IDX_MASK1: s_d.mask[1] = writedata[7:0];
        ain_pkg::IDX_HI0:   s_d.hi[0]   = writedata[7:0];
        ain_pkg::IDX_HI1:   s_d.hi[1]   = writedata[7:0];
        ain_pkg::IDX_LO0:   s_d.lo[0]   = writedata[7:0];
        ain_pkg::IDX_LO1:   s_d.lo[1]   = writedata[7:0];
        default: ;
      endcase
    end

    // event latch: a live event beats a clearing write in the same cycle
    for (int i = 0; i < 2; i++) begin
      if (any_evt[i]) begin
        s_d.behav[i][ain_pkg::BH_LATCH] = 1'b1;
      end
      if (meas_vld[i]) begin
        s_d.meas[i] = meas_in[i];
      end
    end

    // shared outputs also carry the rest of the device's sources
    s_d.fault_n = !(|fault_req || other_fault);
    s_d.int_n   = !(|int_req || other_int);
    s_d.fan1    = (alarm_req[0] && s_q.mask[0][ain_pkg::FM_FAN1])
               || (alarm_req[1] && s_q.mask[1][ain_pkg::FM_FAN1])
               || other_fan1_alarm;
    s_d.fan2    = (alarm_req[0] && s_q.mask[0][ain_pkg::FM_FAN2])
               || (alarm_req[1] && s_q.mask[1][ain_pkg::FM_FAN2])
               || other_fan2_alarm;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.wait_q   <= 1'b1;
      s_q.pin_func <= ain_pkg::PIN_FUNC_RST;
      s_q.behav    <= {2{ain_pkg::BEHAV_RST}};
      s_q.mask     <= {2{ain_pkg::MASK_RST}};
      s_q.hi       <= {2{ain_pkg::HI_RST}};
      s_q.lo       <= {2{ain_pkg::LO_RST}};
      s_q.meas     <= {2{ain_pkg::MEAS_RST}};
      s_q.fault_n  <= 1'b1;
      s_q.int_n    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign readdata             = {24'h000000, s_q.rdata};
  assign waitrequest          = s_q.wait_q;
  assign response             = s_q.resp;
  assign pin_function         = s_q.pin_func;
  assign cascaded_fault_out_n = s_q.fault_n;
  assign int_n                = s_q.int_n;
  assign fan1_alarm           = s_q.fan1;
  assign fan2_alarm           = s_q.fan2;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence seq_req_waiting;
    req && waitrequest;
  endsequence

  sequence seq_ack_once;
    !waitrequest ##1 waitrequest;
  endsequence

  AST_BUS_ACK: assert property (seq_req_waiting |=> seq_ack_once)
    else $error("bus request not answered in exactly one cycle");

  // only the first edge after release sees the counter at zero
  AST_PIN_RESET: assert property (
    !s_q.init_done && s_q.init_cnt == 2'h0 |-> pin_function[2:0] == 3'h7)
    else $error("low pin-function bits not set after reset");

  AST_PIN_BIT7: assert property (pin_function[7] == 1'b0 && readdata[31:8] == 24'h000000)
    else $error("pin-function bit 7 or upper read bits not zero");

  AST_DIODE1: assert property (
    !s_q.init_done && s_q.init_cnt == ain_pkg::SETTLE_CYCLES - 2'h1 && !wr_go
    |=> pin_function[4:3] == {2{!$past(s_q.d1_s2)}})
    else $error("diode 1 strap not reflected in bits 3 and 4");

  AST_DIODE2: assert property (
    !s_q.init_done && s_q.init_cnt == ain_pkg::SETTLE_CYCLES - 2'h1 && !wr_go
    |=> pin_function[6:5] == {2{!$past(s_q.d2_s2)}})
    else $error("diode 2 strap not reflected in bits 5 and 6");

  AST_FAULT_HI: assert property (
    hi_cond[0] && s_q.behav[0][ain_pkg::BH_HI_FAULT] |=> !cascaded_fault_out_n)
    else $error("fault output missing on high-limit exceed");

  AST_INT_LO: assert property (
    lo_cond[1] && s_q.behav[1][ain_pkg::BH_LO_INT] |=> !int_n)
    else $error("interrupt missing on low-limit event");

  AST_FAN1_GATE: assert property (
    !(alarm_req[0] && s_q.mask[0][ain_pkg::FM_FAN1]) && !(alarm_req[1] && s_q.mask[1][ain_pkg::FM_FAN1])
    && !other_fan1_alarm |=> !fan1_alarm)
    else $error("fan 1 alarm without a cause");

  AST_FAULT_LO: assert property (
    lo_cond[0] && s_q.behav[0][ain_pkg::BH_LO_FAULT] |=> !cascaded_fault_out_n)
    else $error("fault output missing on low-limit event");

  AST_ALARM_LO: assert property (
    lo_cond[0] && s_q.behav[0][ain_pkg::BH_LO_ALARM] && s_q.mask[0][ain_pkg::FM_FAN2] |=> fan2_alarm)
    else $error("fan 2 alarm missing on low-limit event");

  AST_FAN2_HI: assert property (
    hi_cond[0] && s_q.behav[0][ain_pkg::BH_HI_ALARM] && s_q.mask[0][ain_pkg::FM_FAN2] |=> fan2_alarm)
    else $error("fan 2 alarm missing");

  AST_LATCH_SET: assert property (any_evt[1] |=> s_q.behav[1][ain_pkg::BH_LATCH] ##1 1'b1)
    else $error("event latch not set");

  AST_LATCH_HOLD: assert property (
    s_q.behav[0][ain_pkg::BH_LATCH] && !(wr_go && idx == ain_pkg::IDX_BEHAV0)
    |=> s_q.behav[0][ain_pkg::BH_LATCH])
    else $error("event latch lost without a clearing write");
endmodule

// >>> shared/ain_pkg.sv
package ain_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_PIN_FUNC = 8'h05;
  localparam logic [7:0] IDX_BEHAV0   = 8'h50;
  localparam logic [7:0] IDX_BEHAV1   = 8'h51;
  localparam logic [7:0] IDX_MASK0    = 8'h58;
  localparam logic [7:0] IDX_MASK1    = 8'h59;
  localparam logic [7:0] IDX_HI0      = 8'ha8;
  localparam logic [7:0] IDX_HI1      = 8'ha9;
  localparam logic [7:0] IDX_LO0      = 8'hb0;
  localparam logic [7:0] IDX_LO1      = 8'hb1;
  localparam logic [7:0] IDX_MEAS0    = 8'hb8;
  localparam logic [7:0] IDX_MEAS1    = 8'hb9;

  localparam int ADDR_W = 10;

  // values after reset, and the pin-function write mask
  localparam logic [7:0] PIN_FUNC_RST = 8'h7f;
  localparam logic [7:0] BEHAV_RST    = 8'h00;
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] HI_RST       = 8'hff;
  localparam logic [7:0] LO_RST       = 8'h00;
  localparam logic [7:0] MEAS_RST     = 8'h00;
  localparam logic [7:0] PIN_FUNC_WM  = 8'h7f;

  // pin-function fields
  localparam int PF_CH0   = 0;
  localparam int PF_CH1   = 1;
  localparam int PF_PIN2  = 2;
  localparam int PF_D1_LO = 3;
  localparam int PF_D1_HI = 4;
  localparam int PF_D2_LO = 5;
  localparam int PF_D2_HI = 6;

  // behaviour fields
  localparam int BH_HI_FAULT = 0;
  localparam int BH_HI_ALARM = 1;
  localparam int BH_HI_INT   = 2;
  localparam int BH_LO_ABOVE = 3;
  localparam int BH_LO_FAULT = 4;
  localparam int BH_LO_ALARM = 5;
  localparam int BH_LO_INT   = 6;
  localparam int BH_LATCH    = 7;

  // fan mask fields
  localparam int FM_FAN1 = 0;
  localparam int FM_FAN2 = 1;

  // cycles after reset release before the diode straps are taken
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// >>> core/limit_channel.sv
`timescale 1ns/10ps
module limit_channel (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       lo_above,
  input  wire logic [7:0] upper_threshold,
  input  wire logic [7:0] lower_threshold,
  input  wire logic [7:0] meas,
  input  wire logic       meas_valid,
  output logic            hi_cond,
  output logic            lo_cond
);
  typedef struct packed {
    logic hi;
    logic lo;
  } chan_state_t;

  chan_state_t s_q;
  chan_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (!enable) begin
      s_d.hi = 1'b0;
      s_d.lo = 1'b0;
    end else if (meas_valid) begin
      s_d.hi = meas > upper_threshold;
      s_d.lo = lo_above ? (meas > lower_threshold) : (meas < lower_threshold);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hi_cond = s_q.hi;
  assign lo_cond = s_q.lo;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  AST_HI_COMPARE: assert property (
    enable && meas_valid |=> hi_cond == ($past(meas) > $past(upper_threshold)))
    else $error("high condition does not follow the new sample");

  AST_LO_DIRECTION: assert property (
    enable && meas_valid && lo_above && meas > lower_threshold |=> lo_cond)
    else $error("low condition missed for the above direction");

  AST_LO_BELOW: assert property (
    enable && meas_valid && !lo_above && meas >= lower_threshold |=> !lo_cond)
    else $error("low condition raised although not below the limit");
endmodule

// >>> testbench/conversion_model.sv
`timescale 1ns/10ps
module conversion_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic       go_ch,
  input  wire logic [7:0] go_val,
  input  wire logic [3:0] lag,
  output logic      [7:0] ch0_val,
  output logic            ch0_vld,
  output logic      [7:0] ch1_val,
  output logic            ch1_vld
);
  logic       pend;
  logic       ch;
  logic [3:0] cnt;
  logic [7:0] val;

  // data lines toggle between results so a stale value never passes for a fresh one
  always @(posedge sys_clk) begin
    ch0_vld <= 1'b0;
    ch1_vld <= 1'b0;
    ch0_val <= ~ch0_val;
    ch1_val <= ~ch1_val;
    if (!rst_n) begin
      pend    <= 1'b0;
      ch0_val <= 8'h00;
      ch1_val <= 8'h00;
    end else if (go) begin
      pend <= 1'b1;
      cnt  <= lag;
      ch   <= go_ch;
      val  <= go_val;
    end else if (pend && cnt != 4'h0) begin
      cnt <= cnt - 4'h1;
    end else if (pend) begin
      pend <= 1'b0;
      if (ch) begin
        ch1_val <= val;
        ch1_vld <= 1'b1;
      end else begin
        ch0_val <= val;
        ch0_vld <= 1'b1;
      end
    end
  end
endmodule

// >>> testbench/analog_limit_events_tb_top.sv
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin bad_count++; $display("BAD %0t got %h want %h", $time, g, e); end end
module analog_limit_events_tb_top;
  typedef struct packed {
    logic [7:0] idx;
    logic       wr;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [1:0] resp;
  } row_t;

  logic        sys_clk, rst_n, read, write, waitrequest, v0, v1, rd1, rd2;
  logic        o_f, o_i, o_a1, o_a2, fault_n, int_n, fan1, fan2, go, go_ch;
  logic [9:0]  address;
  logic [31:0] writedata, readdata, rv;
  logic [3:0]  byteenable, lag;
  logic [1:0]  response, rr;
  logic [7:0]  a0, a1, pin_function, go_val;
  logic [3:0]  outs;
  int          bad_count, checks, cyc;

  assign outs = {fault_n, int_n, fan1, fan2};

  row_t rows [16] = '{
    '{ain_pkg::IDX_PIN_FUNC, 1'b0, 8'h00, 8'h67, 2'h0}, '{ain_pkg::IDX_BEHAV0, 1'b0, 8'h00, 8'h00, 2'h0},
    '{ain_pkg::IDX_BEHAV1, 1'b0, 8'h00, 8'h00, 2'h0}, '{ain_pkg::IDX_MASK0, 1'b0, 8'h00, 8'h00, 2'h0},
    '{ain_pkg::IDX_MASK1, 1'b0, 8'h00, 8'h00, 2'h0}, '{ain_pkg::IDX_HI0, 1'b0, 8'h00, 8'hff, 2'h0},
    '{ain_pkg::IDX_HI1, 1'b0, 8'h00, 8'hff, 2'h0}, '{ain_pkg::IDX_LO0, 1'b0, 8'h00, 8'h00, 2'h0},
    '{ain_pkg::IDX_LO1, 1'b0, 8'h00, 8'h00, 2'h0}, '{ain_pkg::IDX_MEAS0, 1'b0, 8'h00, 8'h00, 2'h0},
    '{ain_pkg::IDX_PIN_FUNC, 1'b1, 8'hff, 8'h7f, 2'h0}, '{ain_pkg::IDX_PIN_FUNC, 1'b1, 8'h00, 8'h00, 2'h0},
    '{ain_pkg::IDX_MASK1, 1'b1, 8'hff, 8'hff, 2'h0}, '{ain_pkg::IDX_MEAS1, 1'b1, 8'h55, 8'h00, 2'h0},
    '{8'h10, 1'b1, 8'haa, 8'h00, 2'h2}, '{8'h10, 1'b0, 8'h00, 8'h00, 2'h2}};

  analog_limit_events dut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .response(response), .analog_in_ch0(a0), .analog_in_ch0_valid(v0), .analog_in_ch1(a1),
    .analog_in_ch1_valid(v1), .remote_diode_1(rd1), .remote_diode_2(rd2), .other_fault(o_f), .other_int(o_i),
    .other_fan1_alarm(o_a1), .other_fan2_alarm(o_a2), .pin_function(pin_function),
    .cascaded_fault_out_n(fault_n), .int_n(int_n), .fan1_alarm(fan1), .fan2_alarm(fan2));

  conversion_model conv (.sys_clk(sys_clk), .rst_n(rst_n), .go(go), .go_ch(go_ch), .go_val(go_val), .lag(lag),
    .ch0_val(a0), .ch0_vld(v0), .ch1_val(a1), .ch1_vld(v1));

  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge sys_clk);
    address   <= {idx, 2'b00};
    read      <= !wr;
    write     <= wr;
    writedata <= {24'h0, wd};
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    rv = readdata;
    rr = response;
    read  <= 1'b0;
    write <= 1'b0;
  endtask

  // waits for the result to land, then three more edges for the registered outputs
  task automatic samp(input logic c, input logic [7:0] v, input logic [3:0] l);
    @(posedge sys_clk);
    go     <= 1'b1;
    go_ch  <= c;
    go_val <= v;
    lag    <= l;
    @(posedge sys_clk);
    go <= 1'b0;
    while (!(v0 | v1)) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic d1, input logic d2);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    rd1   <= d1;
    rd2   <= d2;
    repeat (10) @(posedge sys_clk);
    `CHK(pin_function, 8'h7f)
    rst_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      conclude;
    end
  end

  initial begin
    {rst_n, read, write, go, go_ch, o_f, o_i, o_a1, o_a2} = 9'h000;
    {rd1, rd2, lag, go_val, address, writedata} = 0;
    byteenable = 4'hf;
    do_reset(1'b1, 1'b0);
    foreach (rows[i]) begin
      bus(rows[i].idx, rows[i].wr, rows[i].wd);
      if (rows[i].wr) bus(rows[i].idx, 1'b0, 8'h00);
      `CHK({rv, rr}, {24'h0, rows[i].rd, rows[i].resp})
    end
    bus(ain_pkg::IDX_HI0, 1'b1, 8'h80);
    bus(ain_pkg::IDX_LO0, 1'b1, 8'h20);
    bus(ain_pkg::IDX_MASK0, 1'b1, 8'h01);
    for (int b = 0; b < 3; b++) begin
      bus(ain_pkg::IDX_BEHAV0, 1'b1, 8'h01 << b);
      samp(1'b0, 8'h81, 4'h0);
      `CHK(outs, {b != 0, b != 2, b == 1, 1'b0})
    end
    // slow conversion landing exactly on the limit
    samp(1'b0, 8'h80, 4'h5);
    `CHK(outs, 4'b1100)
    bus(ain_pkg::IDX_BEHAV0, 1'b0, 8'h00);
    `CHK(rv, 32'h84)
    bus(ain_pkg::IDX_BEHAV0, 1'b1, 8'h04);
    bus(ain_pkg::IDX_BEHAV0, 1'b0, 8'h00);
    `CHK(rv, 32'h04)
    bus(ain_pkg::IDX_MASK0, 1'b1, 8'h02);
    for (int b = 4; b < 7; b++) begin
      bus(ain_pkg::IDX_BEHAV0, 1'b1, 8'h01 << b);
      samp(1'b0, 8'h1f, 4'h0);
      `CHK(outs, {b != 4, b != 6, 1'b0, b == 5})
    end
    samp(1'b0, 8'h20, 4'h0);
    `CHK(outs, 4'b1100)
    // a write without its low byte enabled must leave the mask alone
    byteenable <= 4'h0;
    bus(ain_pkg::IDX_MASK0, 1'b1, 8'h55);
    byteenable <= 4'hf;
    bus(ain_pkg::IDX_MASK0, 1'b0, 8'h00);
    `CHK(rv, 32'h02)
    bus(ain_pkg::IDX_BEHAV0, 1'b1, 8'h78);
    samp(1'b0, 8'h21, 4'h0);
    `CHK(outs, 4'b0001)
    samp(1'b0, 8'h1f, 4'h0);
    `CHK(outs, 4'b1100)
    bus(ain_pkg::IDX_PIN_FUNC, 1'b1, 8'h02);
    bus(ain_pkg::IDX_HI1, 1'b1, 8'h10);
    bus(ain_pkg::IDX_BEHAV1, 1'b1, 8'h07);
    samp(1'b1, 8'h50, 4'h0);
    `CHK(outs, 4'b1100)
    bus(ain_pkg::IDX_PIN_FUNC, 1'b1, 8'h00);
    samp(1'b1, 8'h50, 4'h0);
    `CHK(outs, 4'b0011)
    bus(ain_pkg::IDX_BEHAV1, 1'b1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      {o_f, o_i, o_a1, o_a2} <= 4'b1000 >> k;
      repeat (3) @(posedge sys_clk);
      `CHK(outs, {k != 0, k != 1, k == 2, k == 3})
    end
    {o_f, o_i, o_a1, o_a2} <= 4'h0;
    // mid-run reset with the diode straps swapped
    do_reset(1'b0, 1'b1);
    `CHK(pin_function, 8'h1f)
    `CHK(outs, 4'b1100)
    conclude;
  end
endmodule
